//--- hdl/hdr_exposure_control.sv
// HDR exposure sequencer: interleaved and piecewise-linear exposure timing.
// Assumes an APB master on CLOCK and asynchronous exposure and frame pins.
//
// The APB register port was chosen for this implementation.
`timescale 1ns/10ps
module hdr_exposure_control
    import hdr_pkg::*;
#(
    parameter int ROW_W = 11
) (
    input  wire logic              CLOCK,
    input  wire logic              RSTN,
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    input  wire logic              FRAME_REQ,
    input  wire logic              EXPOSURE_PULSE_EVEN,
    input  wire logic              EXPOSURE_PULSE_ODD,
    input  wire logic [ROW_W-1:0]  ROW_INDEX,
    output logic                   INTEGRATE_EVEN,
    output logic                   INTEGRATE_ODD,
    output logic                   ROW_INTEGRATING,
    output logic                   CLIP_ACTIVE,
    output logic      [5:0]        CLIP_LEVEL,
    output logic      [1:0]        CLIP_SLOPE,
    output logic                   EXPOSURE_BUSY,
    output logic                   EXPOSURE_DONE
);
    logic [6:0]  idx;
    logic        mapped, wr_en, rd_setup;
    logic        mono_r, mono_nxt;
    logic [1:0]  ctrl_r, ctrl_nxt;
    logic [23:0] prim_r, prim_nxt;
    logic [23:0] odd_r, odd_nxt;
    logic [23:0] kp1_r, kp1_nxt;
    logic [23:0] kp2_r, kp2_nxt;
    logic [1:0]  slopes_r, slopes_nxt;
    logic [7:0]  fot_r, fot_nxt;
    logic [6:0]  clip2_r, clip2_nxt;
    logic [6:0]  clip3_r, clip3_nxt;
    logic [31:0] prdata_r, prdata_nxt;

    logic [2:0]  pin_level, pin_rise;
    logic        frame_rise, even_rise, odd_rise;
    hdr_state_t  state_r, state_nxt;
    logic        ext_r, ext_nxt;
    logic        dual_r, dual_nxt;
    logic        even_act_r, even_act_nxt;
    logic        odd_act_r, odd_act_nxt;
    logic [31:0] te_r, te_nxt;
    logic [31:0] to_r, to_nxt;
    logic [31:0] k1_r, k1_nxt;
    logic [31:0] k2_r, k2_nxt;
    logic [1:0]  nslope_r, nslope_nxt;
    logic [6:0]  cl2_r, cl2_nxt;
    logic [6:0]  cl3_r, cl3_nxt;
    logic        done_r, done_nxt;
    logic        row_int_r, row_int_nxt;
    logic        clip_act_r, clip_act_nxt;
    logic [5:0]  clip_lvl_r, clip_lvl_nxt;
    logic [1:0]  clip_slope_r, clip_slope_nxt;
    logic        tmr_load, tmr_exp;
    logic [31:0] tmr_val, tmr_cnt;
    logic [31:0] te_new, to_new;

    assign idx      = PADDR[8:2];
    assign wr_en    = PSEL & PENABLE & PWRITE & mapped;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;

    always_comb begin
        case (idx)
            IDX_SENSOR_TYPE, IDX_EXP_CTRL, IDX_SLOPES, IDX_FOT, IDX_CLIP_TWO, IDX_CLIP_THREE,
            IDX_PRIMARY, IDX_PRIMARY + 7'h1, IDX_PRIMARY + 7'h2, IDX_ODD, IDX_ODD + 7'h1, IDX_ODD + 7'h2,
            IDX_KNEE_ONE, IDX_KNEE_ONE + 7'h1, IDX_KNEE_ONE + 7'h2,
            IDX_KNEE_TWO, IDX_KNEE_TWO + 7'h1, IDX_KNEE_TWO + 7'h2: mapped = 1'b1;
            IDX_STATUS: mapped = ~PWRITE;
            default: mapped = 1'b0;
        endcase
        if (PADDR[1:0] != 2'b00 || PADDR[ADDR_W-1]) mapped = 1'b0;
    end

    // Register file writes; three-byte counts sit low byte first.
    always_comb begin
        mono_nxt   = mono_r;
        ctrl_nxt   = ctrl_r;
        prim_nxt   = prim_r;
        odd_nxt    = odd_r;
        kp1_nxt    = kp1_r;
        kp2_nxt    = kp2_r;
        slopes_nxt = slopes_r;
        fot_nxt    = fot_r;
        clip2_nxt  = clip2_r;
        clip3_nxt  = clip3_r;
        if (wr_en) begin
            case (idx)
                IDX_SENSOR_TYPE: mono_nxt = PWDATA[0];
                IDX_EXP_CTRL: ctrl_nxt = PWDATA[1:0];
                IDX_PRIMARY:          prim_nxt[7:0]   = PWDATA[7:0];
                IDX_PRIMARY + 7'h1:   prim_nxt[15:8]  = PWDATA[7:0];
                IDX_PRIMARY + 7'h2:   prim_nxt[23:16] = PWDATA[7:0];
                IDX_ODD:              odd_nxt[7:0]    = PWDATA[7:0];
                IDX_ODD + 7'h1:       odd_nxt[15:8]   = PWDATA[7:0];
                IDX_ODD + 7'h2:       odd_nxt[23:16]  = PWDATA[7:0];
                IDX_KNEE_ONE:         kp1_nxt[7:0]    = PWDATA[7:0];
                IDX_KNEE_ONE + 7'h1:  kp1_nxt[15:8]   = PWDATA[7:0];
                IDX_KNEE_ONE + 7'h2:  kp1_nxt[23:16]  = PWDATA[7:0];
                IDX_KNEE_TWO:         kp2_nxt[7:0]    = PWDATA[7:0];
                IDX_KNEE_TWO + 7'h1:  kp2_nxt[15:8]   = PWDATA[7:0];
                IDX_KNEE_TWO + 7'h2:  kp2_nxt[23:16]  = PWDATA[7:0];
                IDX_SLOPES: if (PWDATA[1:0] != 2'h0) slopes_nxt = PWDATA[1:0];
                IDX_FOT: fot_nxt = PWDATA[7:0];
                IDX_CLIP_TWO: clip2_nxt = PWDATA[6:0];
                IDX_CLIP_THREE: clip3_nxt = PWDATA[6:0];
                default: mono_nxt = mono_r;
            endcase
        end
    end

    // Read data is latched in the setup cycle and presented in the access cycle.
    always_comb begin
        prdata_nxt = prdata_r;
        if (rd_setup) begin
            prdata_nxt = 32'h0;
            case (idx)
                IDX_SENSOR_TYPE:      prdata_nxt[0]   = mono_r;
                IDX_EXP_CTRL:         prdata_nxt[1:0] = ctrl_r;
                IDX_PRIMARY:          prdata_nxt[7:0] = prim_r[7:0];
                IDX_PRIMARY + 7'h1:   prdata_nxt[7:0] = prim_r[15:8];
                IDX_PRIMARY + 7'h2:   prdata_nxt[7:0] = prim_r[23:16];
                IDX_ODD:              prdata_nxt[7:0] = odd_r[7:0];
                IDX_ODD + 7'h1:       prdata_nxt[7:0] = odd_r[15:8];
                IDX_ODD + 7'h2:       prdata_nxt[7:0] = odd_r[23:16];
                IDX_KNEE_ONE:         prdata_nxt[7:0] = kp1_r[7:0];
                IDX_KNEE_ONE + 7'h1:  prdata_nxt[7:0] = kp1_r[15:8];
                IDX_KNEE_ONE + 7'h2:  prdata_nxt[7:0] = kp1_r[23:16];
                IDX_KNEE_TWO:         prdata_nxt[7:0] = kp2_r[7:0];
                IDX_KNEE_TWO + 7'h1:  prdata_nxt[7:0] = kp2_r[15:8];
                IDX_KNEE_TWO + 7'h2:  prdata_nxt[7:0] = kp2_r[23:16];
                IDX_SLOPES:           prdata_nxt[1:0] = slopes_r;
                IDX_FOT:              prdata_nxt[7:0] = fot_r;
                IDX_CLIP_TWO:         prdata_nxt[6:0] = clip2_r;
                IDX_CLIP_THREE:       prdata_nxt[6:0] = clip3_r;
                IDX_STATUS: prdata_nxt[6:0] = {clip_slope_r, clip_act_r, odd_act_r,
                                               even_act_r, ext_r, state_r != ST_IDLE};
                default: prdata_nxt = 32'h0;
            endcase
            if (!mapped) prdata_nxt = 32'h0;
        end
    end

    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            mono_r   <= SENSOR_TYPE_RST;
            ctrl_r   <= EXP_CTRL_RST;
            prim_r   <= PRIMARY_RST;
            odd_r    <= ODD_RST;
            kp1_r    <= KNEE_RST;
            kp2_r    <= KNEE_RST;
            slopes_r <= SLOPES_RST;
            fot_r    <= FOT_RST;
            clip2_r  <= CLIP_RST;
            clip3_r  <= CLIP_RST;
            prdata_r <= 32'h0;
        end else begin
            mono_r   <= mono_nxt;
            ctrl_r   <= ctrl_nxt;
            prim_r   <= prim_nxt;
            odd_r    <= odd_nxt;
            kp1_r    <= kp1_nxt;
            kp2_r    <= kp2_nxt;
            slopes_r <= slopes_nxt;
            fot_r    <= fot_nxt;
            clip2_r  <= clip2_nxt;
            clip3_r  <= clip3_nxt;
            prdata_r <= prdata_nxt;
        end
    end
    assign PRDATA  = prdata_r;
    assign PREADY  = 1'b1;
    assign PSLVERR = PSEL & PENABLE & ~mapped;
    hdr_sync #(.W(3)) u_sync (
        .clk   (CLOCK),
        .rstn  (RSTN),
        .din   ({EXPOSURE_PULSE_ODD, EXPOSURE_PULSE_EVEN, FRAME_REQ}),
        .level (pin_level),
        .rise  (pin_rise)
    );
    assign frame_rise = pin_rise[0];
    assign even_rise  = pin_rise[1];
    assign odd_rise   = pin_rise[2];

    assign te_new = hdr_exp_cycles(prim_r, fot_r);
    assign to_new = ctrl_r[DUAL_BIT] ? hdr_exp_cycles(odd_r, fot_r) : te_new;

    // Sequencer: settings are snapshotted when an exposure starts, except fot_r, which the external-mode overhead reads live.
    always_comb begin
        state_nxt    = state_r;
        ext_nxt      = ext_r;
        dual_nxt     = dual_r;
        even_act_nxt = even_act_r;
        odd_act_nxt  = odd_act_r;
        te_nxt       = te_r;
        to_nxt       = to_r;
        k1_nxt       = k1_r;
        k2_nxt       = k2_r;
        nslope_nxt   = nslope_r;
        cl2_nxt      = cl2_r;
        cl3_nxt      = cl3_r;
        done_nxt     = 1'b0;
        tmr_load     = 1'b0;
        tmr_val      = 32'h1;
        case (state_r)
            ST_IDLE: begin
                ext_nxt    = ctrl_r[EXT_BIT];
                dual_nxt   = ctrl_r[DUAL_BIT];
                te_nxt     = te_new;
                to_nxt     = to_new;
                k1_nxt     = hdr_exp_cycles(kp1_r, fot_r);
                k2_nxt     = hdr_exp_cycles(kp2_r, fot_r);
                nslope_nxt = slopes_r;
                cl2_nxt    = clip2_r;
                cl3_nxt    = clip3_r;
                if (ctrl_r[EXT_BIT]) begin
                    if (even_rise || (odd_rise && ctrl_r[DUAL_BIT])) begin
                        state_nxt    = ST_EXPOSE;
                        even_act_nxt = even_rise;
                        odd_act_nxt  = ctrl_r[DUAL_BIT] ? odd_rise : even_rise;
                    end
                end else if (frame_rise) begin
                    state_nxt = ST_EXPOSE;
                    tmr_load  = 1'b1;
                    tmr_val   = (te_new > to_new) ? te_new : to_new;
                end
            end
            ST_EXPOSE: begin
                if (ext_r) begin
                    if (even_rise) even_act_nxt = 1'b1;
                    if (dual_r ? odd_rise : even_rise) odd_act_nxt = 1'b1;
                    if (frame_rise) begin
                        state_nxt = ST_OVERHEAD;
                        tmr_load  = 1'b1;
                        tmr_val   = hdr_ovh_cycles(fot_r);
                        if (tmr_val == 32'h0) tmr_val = 32'h1;
                    end
                end else begin
                    even_act_nxt = (tmr_cnt != 32'h0) && (tmr_cnt <= te_r);
                    odd_act_nxt  = (tmr_cnt != 32'h0) && (tmr_cnt <= to_r);
                    if (tmr_exp) begin
                        state_nxt    = ST_IDLE;
                        even_act_nxt = 1'b0;
                        odd_act_nxt  = 1'b0;
                        done_nxt     = 1'b1;
                    end
                end
            end
            ST_OVERHEAD: begin
                if (tmr_exp) begin
                    state_nxt    = ST_IDLE;
                    even_act_nxt = 1'b0;
                    odd_act_nxt  = 1'b0;
                    done_nxt     = 1'b1;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // Clip phase follows the remaining exposure; interleave and external mode exclude it.
    always_comb begin
        clip_act_nxt   = 1'b0;
        clip_lvl_nxt   = 6'h0;
        clip_slope_nxt = 2'h1;
        if (state_r == ST_EXPOSE && !ext_r && !dual_r && tmr_cnt != 32'h0) begin
            if (nslope_r >= 2'h2 && tmr_cnt > k1_r) begin
                clip_slope_nxt = 2'h1;
                clip_act_nxt   = cl2_r[CLIP_EN_BIT];
                clip_lvl_nxt   = cl2_r[5:0];
            end else if (nslope_r == 2'h3 && tmr_cnt > k2_r) begin
                clip_slope_nxt = 2'h2;
                clip_act_nxt   = cl3_r[CLIP_EN_BIT];
                clip_lvl_nxt   = cl3_r[5:0];
            end else begin
                clip_slope_nxt = nslope_r;
            end
        end
    end

    assign row_int_nxt = (mono_r ? ROW_INDEX[0] : ROW_INDEX[1]) ? odd_act_r : even_act_r;
    always_ff @(posedge CLOCK or negedge RSTN) begin
        if (!RSTN) begin
            state_r      <= ST_IDLE;
            ext_r        <= 1'b0;
            dual_r       <= 1'b0;
            even_act_r   <= 1'b0;
            odd_act_r    <= 1'b0;
            te_r         <= 32'h1;
            to_r         <= 32'h1;
            k1_r         <= 32'h1;
            k2_r         <= 32'h1;
            nslope_r     <= SLOPES_RST;
            cl2_r        <= CLIP_RST;
            cl3_r        <= CLIP_RST;
            done_r       <= 1'b0;
            row_int_r    <= 1'b0;
            clip_act_r   <= 1'b0;
            clip_lvl_r   <= 6'h0;
            clip_slope_r <= 2'h1;
        end else begin
            state_r      <= state_nxt;
            ext_r        <= ext_nxt;
            dual_r       <= dual_nxt;
            even_act_r   <= even_act_nxt;
            odd_act_r    <= odd_act_nxt;
            te_r         <= te_nxt;
            to_r         <= to_nxt;
            k1_r         <= k1_nxt;
            k2_r         <= k2_nxt;
            nslope_r     <= nslope_nxt;
            cl2_r        <= cl2_nxt;
            cl3_r        <= cl3_nxt;
            done_r       <= done_nxt;
            row_int_r    <= row_int_nxt;
            clip_act_r   <= clip_act_nxt;
            clip_lvl_r   <= clip_lvl_nxt;
            clip_slope_r <= clip_slope_nxt;
        end
    end
    hdr_timer #(.W(32)) u_timer (
        .clk      (CLOCK),
        .rstn     (RSTN),
        .load     (tmr_load),
        .load_val (tmr_val),
        .count    (tmr_cnt),
        .expire   (tmr_exp)
    );
    assign INTEGRATE_EVEN  = even_act_r;
    assign INTEGRATE_ODD   = odd_act_r;
    assign ROW_INTEGRATING = row_int_r;
    assign CLIP_ACTIVE     = clip_act_r;
    assign CLIP_LEVEL      = clip_lvl_r;
    assign CLIP_SLOPE      = clip_slope_r;
    assign EXPOSURE_BUSY   = (state_r != ST_IDLE);
    assign EXPOSURE_DONE   = done_r;
endmodule : hdr_exposure_control

//--- hdl/hdr_pkg.sv
// Constants, types and helpers for the HDR exposure-control block.
// Assumes an APB host and the sequencer clock as the only clock.
package hdr_pkg;
    localparam int          ADDR_W          = 10;
    localparam logic [6:0]  IDX_SENSOR_TYPE = 7'h27;
    localparam logic [6:0]  IDX_EXP_CTRL    = 7'h29;
    localparam logic [6:0]  IDX_PRIMARY     = 7'h2a;
    localparam logic [6:0]  IDX_KNEE_ONE    = 7'h30;
    localparam logic [6:0]  IDX_KNEE_TWO    = 7'h33;
    localparam logic [6:0]  IDX_SLOPES      = 7'h36;
    localparam logic [6:0]  IDX_ODD         = 7'h38;
    localparam logic [6:0]  IDX_FOT         = 7'h49;
    localparam logic [6:0]  IDX_CLIP_TWO    = 7'h59;
    localparam logic [6:0]  IDX_CLIP_THREE  = 7'h5a;
    localparam logic [6:0]  IDX_STATUS      = 7'h7e;
    localparam int          EXT_BIT         = 0;
    localparam int          DUAL_BIT        = 1;
    localparam int          CLIP_EN_BIT     = 6;
    localparam logic        SENSOR_TYPE_RST = 1'b1;
    localparam logic [1:0]  EXP_CTRL_RST    = 2'h0;
    localparam logic [23:0] PRIMARY_RST     = 24'h000800;
    localparam logic [23:0] ODD_RST         = 24'h000800;
    localparam logic [23:0] KNEE_RST        = 24'h000001;
    localparam logic [1:0]  SLOPES_RST      = 2'h1;
    localparam logic [6:0]  CLIP_RST        = 7'h60;
    localparam logic [7:0]  FOT_RST         = 8'h0a;
    localparam logic [31:0] UNIT_CYCLES     = 32'h81;
    localparam logic [31:0] OVH_NUM         = 32'h2b;
    localparam logic [31:0] OVH_DEN         = 32'h64;

    typedef enum logic [1:0] {ST_IDLE, ST_EXPOSE, ST_OVERHEAD} hdr_state_t;

    // Overhead part alone: 129 clocks times 0.43 times the overhead length.
    function automatic logic [31:0] hdr_ovh_cycles(input logic [7:0] fot);
        hdr_ovh_cycles = ({24'h0, fot} * OVH_NUM * UNIT_CYCLES) / OVH_DEN;
    endfunction : hdr_ovh_cycles

    // Full exposure in clocks, never below one cycle.
    function automatic logic [31:0] hdr_exp_cycles(input logic [23:0] cnt, input logic [7:0] fot);
        logic [31:0] c;
        c = {8'h0, cnt} * UNIT_CYCLES + hdr_ovh_cycles(fot);
        hdr_exp_cycles = (c == 32'h0) ? 32'h1 : c;
    endfunction : hdr_exp_cycles
endpackage : hdr_pkg

//--- hdl/hdr_sync.sv
// Two-flop synchroniser with rising-edge detect for external pins.
// Assumes the pins are asynchronous to CLOCK.
`timescale 1ns/10ps
module hdr_sync #(
    parameter int W = 3
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;
    logic [W-1:0] prev_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_r <= '0;
            sync_r <= '0;
            prev_r <= '0;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign level = sync_r;
    assign rise  = sync_r & ~prev_r;
endmodule : hdr_sync

//--- hdl/hdr_timer.sv
// Loadable down counter that pulses expire when it reaches zero.
// Assumes load values of at least one.
`timescale 1ns/10ps
module hdr_timer #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    output logic      [W-1:0] count,
    output logic              expire
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic         exp_r;
    logic         exp_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        exp_nxt = 1'b0;
        if (load) begin
            cnt_nxt = load_val;
        end else if (cnt_r != '0) begin
            cnt_nxt = cnt_r - 1'b1;
            exp_nxt = (cnt_r == {{(W-1){1'b0}}, 1'b1});
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r <= '0;
            exp_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            exp_r <= exp_nxt;
        end
    end

    assign count  = cnt_r;
    assign expire = exp_r;
endmodule : hdr_timer

//--- verif/hdr_ctrl_model.sv
// Camera controller model that drives the exposure and frame pins.
// Assumes one-cycle command codes from the bench on its clock.
`timescale 1ns/10ps
module hdr_ctrl_model (
    input  wire logic       clk,
    input  wire logic [1:0] cmd,
    output logic            pulse_even,
    output logic            pulse_odd,
    output logic            frame_req
);
    logic [3:0] pe = '0;
    logic [3:0] po = '0;
    logic [3:0] pf = '0;
    always @(posedge clk) begin
        pe <= {pe[2:0], cmd == 2'h1};
        po <= {po[2:0], cmd == 2'h2};
        pf <= {pf[2:0], cmd == 2'h3};
    end
    assign pulse_even = |pe;
    assign pulse_odd  = |po;
    assign frame_req  = |pf;
endmodule : hdr_ctrl_model

//--- verif/hdr_exposure_control_assertions.sv
// Port checks for the HDR exposure block.
// Assumes CLOCK is the only clock and RSTN resets asynchronously.
`timescale 1ns/10ps
module hdr_exposure_control_assertions
    import hdr_pkg::*;
(
    input wire logic              CLOCK,
    input wire logic              RSTN,
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic              PSLVERR,
    input wire logic              INTEGRATE_EVEN,
    input wire logic              INTEGRATE_ODD,
    input wire logic              CLIP_ACTIVE,
    input wire logic [1:0]        CLIP_SLOPE,
    input wire logic              EXPOSURE_BUSY,
    input wire logic              EXPOSURE_DONE
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RSTN);
    sequence s_held; EXPOSURE_BUSY [*8]; endsequence
    property p_bad_addr; PSEL && PENABLE && (PADDR[1:0] != 2'h0 || PADDR[9]) |-> PSLVERR; endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("bad address not refused");
    property p_done_once; EXPOSURE_DONE |=> !EXPOSURE_DONE; endproperty
    a_done_once: assert property (p_done_once) else $error("done longer than one cycle");
    property p_done_idle; EXPOSURE_DONE |-> !EXPOSURE_BUSY && $past(EXPOSURE_BUSY); endproperty
    a_done_idle: assert property (p_done_idle) else $error("done without exposure");
    property p_integ_busy; INTEGRATE_EVEN || INTEGRATE_ODD |-> EXPOSURE_BUSY; endproperty
    a_integ_busy: assert property (p_integ_busy) else $error("integrating while idle");
    property p_min_len; $rose(EXPOSURE_BUSY) |-> s_held; endproperty
    a_min_len: assert property (p_min_len) else $error("exposure too short");
    property p_slope_range; CLIP_SLOPE != 2'h0; endproperty
    a_slope_range: assert property (p_slope_range) else $error("slope number zero");
    property p_slope_step; $changed(CLIP_SLOPE) |-> CLIP_SLOPE == $past(CLIP_SLOPE) + 2'h1 || CLIP_SLOPE == 2'h1; endproperty
    a_slope_step: assert property (p_slope_step) else $error("slope skipped");
    property p_clip_idle; !EXPOSURE_BUSY && !$past(EXPOSURE_BUSY) |-> !CLIP_ACTIVE && CLIP_SLOPE == 2'h1; endproperty
    a_clip_idle: assert property (p_clip_idle) else $error("clip outside exposure");
endmodule : hdr_exposure_control_assertions
bind hdr_exposure_control hdr_exposure_control_assertions u_chk (.CLOCK, .RSTN, .PSEL, .PENABLE, .PADDR, .PSLVERR,
    .INTEGRATE_EVEN, .INTEGRATE_ODD, .CLIP_ACTIVE, .CLIP_SLOPE, .EXPOSURE_BUSY, .EXPOSURE_DONE);

//--- verif/hdr_exposure_control_bench.sv
// Self-checking bench for the HDR exposure block over APB.
// Assumes the controller model drives the exposure and frame pins.
`timescale 1ns/10ps
module hdr_exposure_control_bench;
    import hdr_pkg::*;
    logic              clk, rstn, psel, penable, pwrite, pready, pslverr, ie, io, ri, ca, busy, done, fr, pe, po, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [10:0]       row;
    logic [5:0]        lvl, l1, l2;
    logic [1:0]        slope, cmd;
    int                miscompares, checks_done, ce, co, cr, cc, c2;
    logic [6:0]        ix [12] = '{7'h27, 7'h29, 7'h2a, 7'h2b, 7'h2c, 7'h30, 7'h33, 7'h36, 7'h38, 7'h39, 7'h59, 7'h5a};
    logic [7:0]        rv [12] = '{8'h01, 8'h00, 8'h00, 8'h08, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h08, 8'h60, 8'h60};
    hdr_exposure_control u_dut (.CLOCK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .FRAME_REQ(fr),
        .EXPOSURE_PULSE_EVEN(pe), .EXPOSURE_PULSE_ODD(po), .ROW_INDEX(row), .INTEGRATE_EVEN(ie),
        .INTEGRATE_ODD(io), .ROW_INTEGRATING(ri), .CLIP_ACTIVE(ca), .CLIP_LEVEL(lvl), .CLIP_SLOPE(slope),
        .EXPOSURE_BUSY(busy), .EXPOSURE_DONE(done));
    hdr_ctrl_model u_ctrl (.clk(clk), .cmd(cmd), .pulse_even(pe), .pulse_odd(po), .frame_req(fr));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Outputs are tallied on the falling edge, where they are settled.
    always @(negedge clk) begin
        ce += ie;
        co += io;
        cr += ri;
        cc += ca;
        c2 += (slope == 2'h2);
        if (ca) l1 = lvl;
        if (slope == 2'h2) l2 = lvl;
    end
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask : chk
    task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [7:0] d);
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        for (int n = 0; n <= 20; n++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
            if (n == 20) begin
                miscompares++;
                give_verdict();
            end
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
    task automatic wr(input logic [6:0] i, input logic [7:0] d);
        xfer(1'b1, {1'b0, i, 2'b00}, d);
    endtask : wr
    task automatic pin(input logic [1:0] c);
        @(posedge clk);
        cmd <= c;
        @(posedge clk);
        cmd <= 2'h0;
    endtask : pin
    task automatic run(input int pre);
        {ce, co, cr, cc, c2} = '0;
        pin(2'h1);
        repeat (pre) @(posedge clk);
        pin(2'h2);
        repeat (30) @(posedge clk);
        pin(2'h3);
        for (int n = 0; n <= 3000; n++) begin
            @(posedge clk);
            if (done === 1'b1) break;
            if (n == 3000) begin
                miscompares++;
                give_verdict();
            end
        end
    endtask : run
    initial begin
        {psel, penable, pwrite, cmd, paddr, pwdata, rstn, miscompares, checks_done} = '0;
        row = 11'h2;
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        for (int k = 0; k < 12; k++) begin
            xfer(1'b0, {1'b0, ix[k], 2'b00}, 8'h0);
            chk("reset value", rd, {24'h0, rv[k]});
        end
        xfer(1'b1, 10'h201, 8'h55);
        chk("misaligned refused", er, 1);
        wr(IDX_SLOPES, 8'h0);
        xfer(1'b0, {1'b0, IDX_SLOPES, 2'b00}, 8'h0);
        chk("slope zero ignored", rd, 1);
        wr(IDX_PRIMARY, 8'h02);
        wr(IDX_PRIMARY + 7'h1, 8'h00);
        wr(IDX_ODD, 8'h01);
        wr(IDX_ODD + 7'h1, 8'h00);
        wr(IDX_SENSOR_TYPE, 8'h0);
        wr(IDX_EXP_CTRL, 8'h2);
        run(0);
        chk("even minus odd", ce - co, 129);
        chk("even span", ce >= 809 && ce <= 815, 1);
        chk("colour row group", cr, co);
        wr(IDX_EXP_CTRL, 8'h3);
        wr(IDX_SENSOR_TYPE, 8'h1);
        run(40);
        chk("pulse spacing", ce - co, 42);
        chk("mono row group", cr, ce);
        wr(IDX_EXP_CTRL, 8'h0);
        wr(IDX_PRIMARY, 8'h04);
        wr(IDX_KNEE_ONE, 8'h02);
        wr(IDX_SLOPES, 8'h3);
        wr(IDX_CLIP_TWO, 8'h45);
        wr(IDX_CLIP_THREE, 8'h07);
        run(0);
        chk("first segment", cc, 258);
        chk("second segment", c2, 129);
        chk("second clip", l1, 5);
        chk("third clip", l2, 7);
        chk("interleave off", ce, co);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        xfer(1'b0, {1'b0, IDX_SLOPES, 2'b00}, 8'h0);
        chk("slope after reset", rd, 1);
        give_verdict();
    end
endmodule : hdr_exposure_control_bench
